/* hdl/rcd_device.sv */
module rcd_device #(
	parameter int CHANNELS = rcd_pkg::CHANNELS
)(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Controller side
	rcd_link_if.device link,
	// Converter side, signed tenths of a degree Celsius
	input wire logic [CHANNELS-1:0][rcd_pkg::READING_W-1:0] reading_celsius,
	input wire logic fahrenheit,
	input wire logic [CHANNELS-1:0] channel_enable,
	// Open sensor detectors, asynchronous pins
	input wire logic [CHANNELS-1:0] open_sensor_pin
);

	generate
		if (CHANNELS != rcd_pkg::CHANNELS)
		begin : g_bad_channels
			$error("rcd_device: the input image holds exactly eight channels");
		end
	endgenerate

	logic [CHANNELS-1:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
	logic [CHANNELS-1:0] flag_r, flag_nxt;
	logic [rcd_pkg::IDX_W-1:0] ch_r, ch_nxt;
	logic [rcd_pkg::IMAGE_W-1:0] image_r, image_nxt;

	// Round robin over enabled channels; a lone channel repeats every scan
	function automatic logic [rcd_pkg::IDX_W-1:0] next_enabled(
		input logic [rcd_pkg::IDX_W-1:0] cur,
		input logic [CHANNELS-1:0] en
	);
		logic [rcd_pkg::IDX_W-1:0] cand;
		logic found;
		next_enabled = cur;
		found = 1'b0;
		for (int k = 1; k <= CHANNELS; k++)
		begin
			cand = rcd_pkg::IDX_W'(cur + rcd_pkg::IDX_W'(k));
			if (!found && en[cand])
			begin
				next_enabled = cand;
				found = 1'b1;
			end
		end
	endfunction

	// Sign plus magnitude in tenths; magnitude saturates at the 15-bit limit
	function automatic logic [rcd_pkg::READING_W-1:0] to_sign_mag(
		input logic [rcd_pkg::READING_W-1:0] c10,
		input logic fahr
	);
		logic signed [rcd_pkg::CONV_W-1:0] wide;
		logic [rcd_pkg::CONV_W-1:0] mag;
		logic neg;
		wide = {{(rcd_pkg::CONV_W - rcd_pkg::READING_W){c10[rcd_pkg::READING_W-1]}}, c10};
		if (fahr)
			wide = rcd_pkg::CONV_W'((wide * rcd_pkg::F_MUL) / rcd_pkg::F_DIV
				+ rcd_pkg::F_OFFSET_TENTHS);
		neg = wide[rcd_pkg::CONV_W-1];
		mag = neg ? rcd_pkg::CONV_W'(-wide) : rcd_pkg::CONV_W'(wide);
		if (mag > rcd_pkg::MAG_MAX)
			mag = rcd_pkg::MAG_MAX;
		to_sign_mag = {neg, mag[rcd_pkg::MAG_W-1:0]}; // see R10
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Open sensor pins: three stages, a change counts when stages two and three agree
	always_comb
	begin
		s1_nxt = open_sensor_pin;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++)
		begin : g_flag
			assign flag_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : flag_r[i]; // see R19
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////

	// Image is rebuilt every clock so the controller may sample at any time
	always_comb
	begin
		ch_nxt = ch_r;
		if (link.scan_refresh)
			ch_nxt = next_enabled(ch_r, channel_enable); // see R01 see R20
		image_nxt = '0;
		// Reading and index come from one register, never out of step
		image_nxt[rcd_pkg::READING_W-1:0] =
			to_sign_mag(reading_celsius[ch_nxt], fahrenheit); // see R02 see R16 see R17 see R21
		image_nxt[rcd_pkg::CHANNEL_INDEX_FIRST_POINT +: rcd_pkg::IDX_W] = ch_nxt; // see R03 see R04
		image_nxt[rcd_pkg::FIRST_OPEN_SENSOR_FLAG_POINT +: CHANNELS] = flag_r; // see R12
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			flag_r <= '0;
			ch_r <= '0;
			image_r <= '0;
		end
		else
		begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			flag_r <= flag_nxt;
			ch_r <= ch_nxt;
			image_r <= image_nxt; // see R18
		end
	end

	assign link.input_image = image_r;

endmodule

/* hdl/rcd_host.sv */
// How it works
// R01 - Device presents one channel per scan
// R02 - Reading sits on lowest sixteen points
// R03 - Channel index binary, 000 is channel one
// R04 - Index on three points above reading
// R05 - Store reading at base plus index
// R06 - Loop repeats once per channel in use; the code repeats the loop count, clipped to eight, not the enabled count
// R07 - Loop samples points immediately each repetition
// R08 - Loop lengthens scan; run only on demand
// R09 - No loop method on remote base
// R10 - Bit 15 marks negative, magnitude below
// R11 - Strip sign bit before using reading; the loop store keeps bit 15
// R12 - Eight open-sensor flags, channel one lowest
// R13 - Accept only matching index, flag clear; the loop store takes the reading even with the flag set
// R14 - Sign detection runs before any use
// R15 - Keep readings binary for control loops
// R16 - Readings in tenths of a degree
// R17 - Fahrenheit or Celsius for all curves
// R18 - Points refresh continually, no handshake
// R19 - Flag follows open sensor circuit
// R20 - Disabled channels are skipped in rotation
// R21 - Reading and index change together
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
module rcd_host #(
	parameter int SCAN_CYCLES = rcd_pkg::SCAN_CYCLES,
	parameter int CHANNELS = rcd_pkg::CHANNELS
)(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [rcd_pkg::AVS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Input module link
	rcd_link_if.host link,
	// User side status
	output logic [CHANNELS-1:0] channel_negative,
	output logic loop_busy
);

	localparam int CNT_W = $clog2(SCAN_CYCLES);
	localparam logic [CNT_W-1:0] SCAN_LAST = CNT_W'(SCAN_CYCLES - 1);

	generate
		if (SCAN_CYCLES < 4 || CHANNELS != rcd_pkg::CHANNELS)
		begin : g_bad_params
			$error("rcd_host: scan needs four cycles and exactly eight channels");
		end
	endgenerate

	rcd_pkg::rcd_host_state_t state_r, state_nxt;
	logic [CNT_W-1:0] scan_cnt_r, scan_cnt_nxt;
	logic [rcd_pkg::LOOP_COUNT_W-1:0] loop_count_r, loop_count_nxt;
	logic [rcd_pkg::LOOP_COUNT_W-1:0] loop_left_r, loop_left_nxt;
	logic remote_r, remote_nxt;
	logic scan_en_r, scan_en_nxt;
	logic refused_r, refused_nxt;
	logic go_pend_r, go_pend_nxt;
	logic refresh_r, refresh_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [rcd_pkg::IDX_W-1:0] last_idx_r, last_idx_nxt;
	logic [CHANNELS-1:0] neg_r, neg_nxt;
	logic [rcd_pkg::READING_W-1:0] scan_store_r [CHANNELS];
	logic [rcd_pkg::READING_W-1:0] scan_store_nxt [CHANNELS];
	logic [rcd_pkg::READING_W-1:0] loop_store_r [CHANNELS];
	logic [rcd_pkg::READING_W-1:0] loop_store_nxt [CHANNELS];

	logic cmd;
	logic wr_take;
	logic scan_end;
	logic [rcd_pkg::IDX_W-1:0] img_idx;
	logic img_sign;
	logic [rcd_pkg::MAG_W-1:0] img_mag;
	logic [CHANNELS-1:0] img_flags;
	logic [rcd_pkg::IDX_W-1:0] addr_idx;

	////////////////////////////////////////////////////////////////////////////////

	// Image fields, read straight off the link points
	assign img_idx = link.input_image[rcd_pkg::CHANNEL_INDEX_FIRST_POINT +: rcd_pkg::IDX_W];
	assign img_sign = link.input_image[rcd_pkg::READING_SIGN_POINT];
	assign img_mag = link.input_image[rcd_pkg::MAG_W-1:0];
	assign img_flags = link.input_image[rcd_pkg::FIRST_OPEN_SENSOR_FLAG_POINT +: CHANNELS];

	assign cmd = avs_read | avs_write;
	assign wr_take = avs_write & ack_r;
	assign scan_end = (scan_cnt_r == SCAN_LAST);
	assign addr_idx = avs_address[rcd_pkg::STORE_IDX_LSB +: rcd_pkg::IDX_W];

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		state_nxt = state_r;
		loop_count_nxt = loop_count_r;
		loop_left_nxt = loop_left_r;
		remote_nxt = remote_r;
		scan_en_nxt = scan_en_r;
		refused_nxt = refused_r;
		go_pend_nxt = go_pend_r;
		last_idx_nxt = last_idx_r;
		neg_nxt = neg_r;
		scan_store_nxt = scan_store_r;
		loop_store_nxt = loop_store_r;
		refresh_nxt = 1'b0;
		scan_cnt_nxt = scan_end ? '0 : CNT_W'(scan_cnt_r + 1'b1);

		// Bus writes first, so that hardware sets below win over a clear
		if (wr_take)
		begin
			case (avs_address)
				rcd_pkg::REG_CTRL:
				begin
					remote_nxt = avs_writedata[rcd_pkg::CTRL_REMOTE_BASE];
					scan_en_nxt = avs_writedata[rcd_pkg::CTRL_SCAN_EN];
					if (avs_writedata[rcd_pkg::CTRL_LOOP_GO])
						go_pend_nxt = 1'b1; // see R08
				end
				rcd_pkg::REG_LOOP_COUNT:
				begin
					// Repeats above the channel count would only re-read channels
					if (avs_writedata[rcd_pkg::LOOP_COUNT_W-1:0] > rcd_pkg::LOOP_COUNT_W'(CHANNELS))
						loop_count_nxt = rcd_pkg::LOOP_COUNT_W'(CHANNELS);
					else
						loop_count_nxt = avs_writedata[rcd_pkg::LOOP_COUNT_W-1:0];
				end
				rcd_pkg::REG_STATUS:
				begin
					if (avs_writedata[rcd_pkg::ST_LOOP_REFUSED])
						refused_nxt = 1'b0;
				end
				default:
				begin
				end
			endcase
		end

		case (state_r)
			rcd_pkg::HS_IDLE:
			begin
				if (scan_end && scan_en_r)
				begin
					// End-of-scan refresh: one channel taken per scan
					for (int c = 0; c < CHANNELS; c++)
					begin
						if (img_idx == rcd_pkg::IDX_W'(c) && !img_flags[c]) // see R13
						begin
							neg_nxt[c] = img_sign; // see R14
							scan_store_nxt[c] = {1'b0, img_mag}; // see R05 see R11 see R15
						end
					end
					last_idx_nxt = img_idx;
					refresh_nxt = 1'b1; // see R01
				end
				else if (go_pend_r)
				begin
					go_pend_nxt = 1'b0;
					if (remote_r)
						refused_nxt = 1'b1; // see R09
					else if (loop_count_r != '0)
					begin
						loop_left_nxt = loop_count_r; // see R06
						state_nxt = rcd_pkg::HS_LOOP_SAMPLE;
					end
				end
			end
			rcd_pkg::HS_LOOP_SAMPLE:
			begin
				// Points taken now, not at the end-of-scan refresh
				loop_store_nxt[img_idx] = link.input_image[rcd_pkg::READING_W-1:0]; // see R05 see R07
				if (!img_flags[img_idx])
					neg_nxt[img_idx] = img_sign; // see R14
				last_idx_nxt = img_idx;
				refresh_nxt = 1'b1;
				loop_left_nxt = rcd_pkg::LOOP_COUNT_W'(loop_left_r - 1'b1);
				state_nxt = rcd_pkg::HS_LOOP_SETTLE;
			end
			rcd_pkg::HS_LOOP_SETTLE:
			begin
				// One cycle for the module to present the next channel
				if (loop_left_r == '0)
					state_nxt = rcd_pkg::HS_IDLE;
				else
					state_nxt = rcd_pkg::HS_LOOP_SAMPLE; // see R06
			end
			default:
			begin
				state_nxt = rcd_pkg::HS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////

	// Avalon slave: one wait cycle on every access, read data registered
	always_comb
	begin
		ack_nxt = cmd & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r)
		begin
			rdata_nxt = '0;
			if (avs_address == rcd_pkg::REG_CTRL)
			begin
				rdata_nxt[rcd_pkg::CTRL_REMOTE_BASE] = remote_r;
				rdata_nxt[rcd_pkg::CTRL_SCAN_EN] = scan_en_r;
			end
			else if (avs_address == rcd_pkg::REG_LOOP_COUNT)
				rdata_nxt[rcd_pkg::LOOP_COUNT_W-1:0] = loop_count_r;
			else if (avs_address == rcd_pkg::REG_STATUS)
			begin
				rdata_nxt[rcd_pkg::ST_LOOP_BUSY] = (state_r != rcd_pkg::HS_IDLE) | go_pend_r;
				rdata_nxt[rcd_pkg::ST_LOOP_REFUSED] = refused_r;
				rdata_nxt[rcd_pkg::ST_LAST_IDX +: rcd_pkg::IDX_W] = last_idx_r;
			end
			else if (avs_address == rcd_pkg::REG_NEGATIVE)
				rdata_nxt[CHANNELS-1:0] = neg_r;
			else if ((avs_address & ~rcd_pkg::STORE_IDX_MASK) == rcd_pkg::SCAN_STORE_BASE_WORD)
				rdata_nxt[rcd_pkg::READING_W-1:0] = scan_store_r[addr_idx];
			else if ((avs_address & ~rcd_pkg::STORE_IDX_MASK) == rcd_pkg::LOOP_STORE_BASE_WORD)
				rdata_nxt[rcd_pkg::READING_W-1:0] = loop_store_r[addr_idx];
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= rcd_pkg::HS_IDLE;
			scan_cnt_r <= '0;
			loop_count_r <= rcd_pkg::LOOP_COUNT_RESET;
			loop_left_r <= '0;
			remote_r <= rcd_pkg::REMOTE_RESET;
			scan_en_r <= rcd_pkg::SCAN_EN_RESET;
			refused_r <= 1'b0;
			go_pend_r <= 1'b0;
			refresh_r <= 1'b0;
			ack_r <= 1'b0;
			rdata_r <= '0;
			last_idx_r <= '0;
			neg_r <= '0;
			for (int c = 0; c < CHANNELS; c++)
			begin
				scan_store_r[c] <= '0;
				loop_store_r[c] <= '0;
			end
		end
		else
		begin
			state_r <= state_nxt;
			scan_cnt_r <= scan_cnt_nxt;
			loop_count_r <= loop_count_nxt;
			loop_left_r <= loop_left_nxt;
			remote_r <= remote_nxt;
			scan_en_r <= scan_en_nxt;
			refused_r <= refused_nxt;
			go_pend_r <= go_pend_nxt;
			refresh_r <= refresh_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			last_idx_r <= last_idx_nxt;
			neg_r <= neg_nxt;
			scan_store_r <= scan_store_nxt;
			loop_store_r <= loop_store_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = cmd & ~ack_r;
	assign link.scan_refresh = refresh_r;
	assign channel_negative = neg_r;
	assign loop_busy = (state_r != rcd_pkg::HS_IDLE);

endmodule

/* shared/rcd_link_if.sv */
interface rcd_link_if;
	// 32 discrete input points seen by the controller
	logic [rcd_pkg::IMAGE_W-1:0] input_image;
	// One-cycle pulse: end of a scan or one loop repetition
	logic scan_refresh;

	modport device
	(
		output input_image,
		input scan_refresh
	);

	modport host
	(
		input input_image,
		output scan_refresh
	);
endinterface

/* shared/rcd_pkg.sv */
package rcd_pkg;

	// Input image layout, in discrete points
	localparam int CHANNELS = 8;
	localparam int IDX_W = 3;
	localparam int READING_W = 16;
	localparam int MAG_W = 15;
	localparam int IMAGE_W = 32;
	localparam int READING_SIGN_POINT = 15;
	localparam int CHANNEL_INDEX_FIRST_POINT = 16;
	localparam int FIRST_OPEN_SENSOR_FLAG_POINT = 24;
	localparam int LAST_OPEN_SENSOR_FLAG_POINT = 31;

	// Celsius tenths to Fahrenheit tenths: F = C * 9 / 5 + 32.0
	localparam int F_MUL = 9;
	localparam int F_DIV = 5;
	localparam int F_OFFSET_TENTHS = 320;
	localparam int CONV_W = 20;
	localparam logic [CONV_W-1:0] MAG_MAX = 20'h07FFF;

	// Controller scan period
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCAN_PERIOD_NS = 1000000;
	localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;

	// Controller register map, byte addresses
	localparam int AVS_ADDR_W = 7;
	localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 7'h00;
	localparam logic [AVS_ADDR_W-1:0] REG_LOOP_COUNT = 7'h04;
	localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 7'h08;
	localparam logic [AVS_ADDR_W-1:0] REG_NEGATIVE = 7'h0C;
	localparam logic [AVS_ADDR_W-1:0] SCAN_STORE_BASE_WORD = 7'h20;
	localparam logic [AVS_ADDR_W-1:0] LOOP_STORE_BASE_WORD = 7'h40;
	localparam logic [AVS_ADDR_W-1:0] STORE_IDX_MASK = 7'h1C;
	localparam int STORE_IDX_LSB = 2;

	// Register fields
	localparam int CTRL_LOOP_GO = 0;
	localparam int CTRL_REMOTE_BASE = 1;
	localparam int CTRL_SCAN_EN = 2;
	localparam int ST_LOOP_BUSY = 0;
	localparam int ST_LOOP_REFUSED = 1;
	localparam int ST_LAST_IDX = 4;
	localparam int LOOP_COUNT_W = 4;
	localparam logic [LOOP_COUNT_W-1:0] LOOP_COUNT_RESET = 4'h8;
	localparam logic REMOTE_RESET = 1'h0;
	localparam logic SCAN_EN_RESET = 1'h1;

	typedef enum logic [2:0]
	{
		HS_IDLE = 3'b001,
		HS_LOOP_SAMPLE = 3'b010,
		HS_LOOP_SETTLE = 3'b100
	} rcd_host_state_t;

endpackage

/* tb/rcd_properties.sv */
module rcd_properties #(
	parameter int SCAN_CYCLES = rcd_pkg::SCAN_CYCLES
)(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Link signals
	input wire logic [rcd_pkg::IMAGE_W-1:0] input_image,
	input wire logic scan_refresh
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] gap_r;
	logic [15:0] gap_nxt;

	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	// Saturating count of cycles since the last refresh, so a stuck host still trips
	always_comb
	begin
		gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
		if (scan_refresh)
			gap_nxt = 16'h0000;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			gap_r <= 16'h0000;
		else
			gap_r <= gap_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	a_index_holds: assert property (!scan_refresh |=> $stable(input_image[18:16]))
		else $error("channel index moved without a refresh");
	a_gap_points_zero: assert property (input_image[23:19] == 5'h00)
		else $error("unused status points not zero");
	a_refresh_pulse: assert property (scan_refresh |=> !scan_refresh)
		else $error("refresh longer than one cycle");
	a_refresh_period: assert property (gap_r <= 16'(SCAN_CYCLES + 2))
		else $error("refresh missing for more than one scan");
	a_sign_magnitude: assert property (input_image[15] |-> input_image[14:0] != 15'h0000)
		else $error("negative reading with zero magnitude");
	a_reset_clear: assert property ($rose(resetn) |-> input_image == 32'h00000000)
		else $error("image not cleared by reset");
	a_reset_quiet: assert property ($rose(resetn) |-> !scan_refresh [*3])
		else $error("refresh too soon after reset");
endmodule

/* tb/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SCAN = 16;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [6:0] avs_address = 7'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] channel_negative;
	logic loop_busy;
	logic [7:0][15:0] reading_celsius = '0;
	logic fahrenheit = 1'b0;
	logic [7:0] channel_enable = 8'hFF;
	logic [7:0] open_sensor_pin = 8'h00;
	logic [31:0] rd;
	logic [2:0] last_idx;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	rcd_link_if link();

	rcd_device i_rcd_device(.clock(clock), .resetn(resetn), .link(link),
		.reading_celsius(reading_celsius), .fahrenheit(fahrenheit),
		.channel_enable(channel_enable), .open_sensor_pin(open_sensor_pin));

	rcd_host #(.SCAN_CYCLES(SCAN)) i_rcd_host(.clock(clock), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link),
		.channel_negative(channel_negative), .loop_busy(loop_busy));

	rcd_properties #(.SCAN_CYCLES(SCAN)) i_rcd_properties(.clock(clock), .resetn(resetn),
		.input_image(link.input_image), .scan_refresh(link.scan_refresh));

	always #20 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered just after an edge; one idle cycle after release keeps strobes clean
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0)
			@(posedge clock);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask

	function automatic logic [15:0] val(input int i);
		return (i % 2 == 1) ? 16'(-(i * 111 + 3)) : 16'(i * 111 + 3);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			report_and_stop();
		end
	end

	initial
	begin
		for (int i = 0; i < 8; i++)
			reading_celsius[i] <= val(i);
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rdchk(rcd_pkg::REG_CTRL, 32'h00000004);
		rdchk(rcd_pkg::REG_LOOP_COUNT, 32'h00000008);
		rdchk(7'h10, 32'h00000000);
		// One channel per scan, stored by index with the sign stripped
		repeat (10 * SCAN) @(posedge clock);
		for (int i = 0; i < 8; i++)
			rdchk(rcd_pkg::SCAN_STORE_BASE_WORD + 7'(4 * i), {17'h00000, 15'(i * 111 + 3)});
		rdchk(rcd_pkg::REG_NEGATIVE, 32'h000000AA);
		chk(32'(channel_negative), 32'h000000AA);
		// Open sensor on channel three: flag up, stored value frozen
		open_sensor_pin <= 8'h04;
		repeat (8) @(posedge clock);
		chk(32'(link.input_image[31:24]), 32'h00000004);
		reading_celsius[2] <= 16'h0100;
		repeat (10 * SCAN) @(posedge clock);
		rdchk(rcd_pkg::SCAN_STORE_BASE_WORD + 7'h08, 32'h000000E1);
		// Loop over all channels, count clipped to eight
		bus(1'b1, rcd_pkg::REG_LOOP_COUNT, 32'h00000009);
		rdchk(rcd_pkg::REG_LOOP_COUNT, 32'h00000008);
		bus(1'b1, rcd_pkg::REG_CTRL, 32'h00000005);
		// A go that meets a scan end starts one cycle late, so look two edges on
		repeat (2) @(posedge clock);
		chk(32'(loop_busy), 32'h00000001);
		do
			bus(1'b0, rcd_pkg::REG_STATUS, 32'h00000000);
		while (rd[0] !== 1'b0);
		chk(32'(loop_busy), 32'h00000000);
		for (int i = 0; i < 8; i++)
			rdchk(rcd_pkg::LOOP_STORE_BASE_WORD + 7'(4 * i), (i == 2) ? 32'h00000100 :
				{16'h0000, i % 2 == 1, 15'(i * 111 + 3)});
		open_sensor_pin <= 8'h00;
		repeat (8) @(posedge clock);
		chk(32'(link.input_image[31:24]), 32'h00000000);
		// Loop refused on a remote base, then flag cleared by writing one
		bus(1'b1, rcd_pkg::REG_CTRL, 32'h00000007);
		// The go may wait out a scan end before it is refused
		do
			bus(1'b0, rcd_pkg::REG_STATUS, 32'h00000000);
		while (rd[0] !== 1'b0);
		chk(32'(rd[1:0]), 32'h00000002);
		bus(1'b1, rcd_pkg::REG_STATUS, 32'h00000002);
		bus(1'b0, rcd_pkg::REG_STATUS, 32'h00000000);
		chk(32'(rd[1:0]), 32'h00000000);
		bus(1'b1, rcd_pkg::REG_CTRL, 32'h00000004);
		// Fahrenheit tenths, positive and negative
		fahrenheit <= 1'b1;
		reading_celsius[0] <= 16'h03E8;
		reading_celsius[1] <= 16'hFE70;
		repeat (10 * SCAN) @(posedge clock);
		rdchk(rcd_pkg::SCAN_STORE_BASE_WORD, 32'h00000848);
		rdchk(rcd_pkg::SCAN_STORE_BASE_WORD + 7'h04, 32'h00000190);
		// Two channels enabled: they alternate on the wire
		channel_enable <= 8'h0A;
		repeat (2 * SCAN) @(posedge clock);
		// Take the reference index only once a refresh has settled
		while (link.scan_refresh !== 1'b1)
			@(posedge clock);
		repeat (2) @(posedge clock);
		last_idx = link.input_image[18:16];
		repeat (4)
		begin
			@(posedge clock);
			while (link.scan_refresh !== 1'b1)
				@(posedge clock);
			repeat (2) @(posedge clock);
			chk(32'(link.input_image[18:16]), (last_idx == 3'h1) ? 32'h3 : 32'h1);
			chk(32'(link.input_image[15:0]), (last_idx == 3'h1) ? 32'h811C : 32'h8190);
			last_idx = link.input_image[18:16];
		end
		report_and_stop();
	end
endmodule
